// ===== dpdt_top.sv
// dual prescaled down timer with register port and timer pin
// Function
// R1 - counter reaching zero sets the zero flag, bit 7 of control
// R2 - software clears the zero flag; hardware never clears it
// R3 - timer request is high while enable bit 6 and zero flag are one
// R4 - timer 1 control bit 5 makes the pin input (0) or output (1)
// R5 - output mode: bit 4 goes to pin on zero flag rise; input: mode
// R6 - run bit 3 low holds prescaler at 7Fh, stops prescaler and counter
// R7 - run bit high lets the prescaler count down and clock the counter
// R8 - tap select bits 2..0 divide by 1 up to 128 in powers of two
// R9 - counters readable and writable at 0D3h and 0D6h
// R10 - prescaler register holds bits 6..0, bit 7 reads zero
// R11 - software writes one to timer 2 bit 5; bit 4 is ignored
// R12 - timer 1 input: bit 4 low counts pin rises, high gates clock
// R13 - prescalers fed by clock over 12, timer 1 optionally by pin
// R14 - reset: counters 0FFh, prescalers 07Fh, control registers zero
// R15 - counter write beats decrement to zero; writing 00h sets flag
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module dpdt_top (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic TPIN_I,
	output logic TPIN_O,
	output logic TPIN_OE,
	output logic T1_REQ,
	output logic T2_REQ,
	output logic IRQ
);
	import dpdt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	// divider and timer pin sampling
	logic [3:0] div_q;
	logic [3:0] div_d;
	logic div_tick;
	logic pin_s;
	logic pin_prev_q;
	logic pin_rise;

	// prescaler feeds and taps
	logic [1:0] tick;
	logic [1:0] fire;
	logic [1:0] run;
	logic [1:0] ld_psc;
	logic [6:0] timer1_prescaler [2];

	// counters, control registers and their decoded offsets
	logic [7:0] cnt_q [2];
	logic [7:0] cnt_d [2];
	logic [7:0] ctl_q [2];
	logic [7:0] ctl_d [2];
	logic [7:0] a_psc [2];
	logic [7:0] a_cnt [2];
	logic [7:0] a_ctl [2];
	logic [1:0] zero_set;
	logic [1:0] zero_rise;

	// timer 1 output latch
	logic pin_o_q;
	logic pin_o_d;

	// interrupt status, mask and registered requests
	logic [1:0] ist_q;
	logic [1:0] ist_d;
	logic [1:0] imsk_q;
	logic [1:0] imsk_d;
	logic [1:0] req_q;
	logic [1:0] req_d;
	logic irq_q;
	logic irq_d;

	// read data register
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// offsets per timer, indexed like the timer loops
	assign a_psc[0] = ADDR_T1_PSC;
	assign a_psc[1] = ADDR_T2_PSC;
	assign a_cnt[0] = ADDR_T1_CNT;
	assign a_cnt[1] = ADDR_T2_CNT;
	assign a_ctl[0] = ADDR_T1_CTL;
	assign a_ctl[1] = ADDR_T2_CTL;

	////////////////////////////////////////////////////////////////////////
	// clock over twelve and timer pin input

	// one-cycle enable every twelve clocks
	always_comb begin
		div_tick = (div_q == DIV_LAST); // R13
		div_d = div_tick ? 4'h0 : div_q + 4'h1;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_d;
		end
	end

	dpdt_sync u_pin_sync (
		.clk(CLK),
		.rst(RST),
		.d(TPIN_I),
		.q(pin_s)
	);

	// edge detector works on the synchronised level only
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_s;
		end
	end

	assign pin_rise = pin_s && !pin_prev_q;

	// prescaler input selection per timer
	always_comb begin
		if (ctl_q[0][BIT_PIN_DIR]) begin
			tick[0] = div_tick; // R13
		end else if (ctl_q[0][BIT_PIN_DATA]) begin
			tick[0] = div_tick && pin_s; // R12
		end else begin
			// a pin rise reaches the tick two clocks late
			tick[0] = pin_rise; // R12
		end
		tick[1] = div_tick; // R13
	end

	////////////////////////////////////////////////////////////////////////
	// prescalers

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			run[i] = ctl_q[i][BIT_RUN]; // R6
			// the prescaler drops a load while its run bit is low
			ld_psc[i] = WR && (ADDR == a_psc[i]);
		end
	end

	dpdt_presc u_psc1 (
		.clk(CLK),
		.rst(RST),
		.run(run[0]),
		.tick(tick[0]),
		.ld(ld_psc[0]),
		.ld_val(WDATA[6:0]),
		.tap(ctl_q[0][TAP_MSB:0]),
		.timer1_prescaler(timer1_prescaler[0]),
		.fire(fire[0])
	);

	dpdt_presc u_psc2 (
		.clk(CLK),
		.rst(RST),
		.run(run[1]),
		.tick(tick[1]),
		.ld(ld_psc[1]),
		.ld_val(WDATA[6:0]),
		.tap(ctl_q[1][TAP_MSB:0]),
		.timer1_prescaler(timer1_prescaler[1]),
		.fire(fire[1])
	);

	////////////////////////////////////////////////////////////////////////
	// counters and status/control registers

	// next counter and control values; set of the zero flag beats clear
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cnt_d[i] = cnt_q[i];
			zero_set[i] = 1'b0;
			if (WR && (ADDR == a_cnt[i])) begin
				cnt_d[i] = WDATA; // R9
				zero_set[i] = (WDATA == 8'h00); // R15
			end else if (run[i] && fire[i]) begin
				// from 00 the count wraps to FF and sets no flag
				cnt_d[i] = cnt_q[i] - 8'h01;
				zero_set[i] = (cnt_q[i] == 8'h01); // R1
			end
			ctl_d[i] = ctl_q[i];
			if (WR && (ADDR == a_ctl[i])) begin
				ctl_d[i] = WDATA; // R2
			end
			ctl_d[i][BIT_ZERO] = ctl_d[i][BIT_ZERO] | zero_set[i]; // R1
			zero_rise[i] = !ctl_q[i][BIT_ZERO] && ctl_d[i][BIT_ZERO];
			req_d[i] = ctl_d[i][BIT_IRQ_EN] && ctl_d[i][BIT_ZERO]; // R3
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < 2; i++) begin
				cnt_q[i] <= CNT_RST; // R14
				ctl_q[i] <= CTL_RST; // R14
			end
			req_q <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				cnt_q[i] <= cnt_d[i];
				ctl_q[i] <= ctl_d[i];
			end
			req_q <= req_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timer 1 output latch

	// data bit is latched to the pin when the zero flag rises
	always_comb begin
		pin_o_d = pin_o_q;
		if (zero_rise[0]) begin
			// latched in either pin mode, driven only in output mode
			pin_o_d = ctl_d[0][BIT_PIN_DATA]; // R5
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_o_q <= 1'b0;
		end else begin
			pin_o_q <= pin_o_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status and mask

	// sticky events, write one to clear, new event wins over clear
	always_comb begin
		ist_d = ist_q;
		imsk_d = imsk_q;
		if (WR && (ADDR == ADDR_IRQ_STAT)) begin
			ist_d = ist_q & ~WDATA[1:0];
		end
		if (WR && (ADDR == ADDR_IRQ_MASK)) begin
			imsk_d = WDATA[1:0];
		end
		// applied after the clear so a new event survives it
		ist_d = ist_d | zero_rise;
		irq_d = |(ist_d & imsk_d);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ist_q <= IRQ_RST;
			imsk_q <= IRQ_RST;
			irq_q <= 1'b0;
		end else begin
			ist_q <= ist_d;
			imsk_q <= imsk_d;
			irq_q <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port

	// read data stand in the cycle after the read strobe only
	always_comb begin
		rdata_d = 8'h00;
		if (RD) begin
			// reads clear nothing, so a stray read is harmless
			unique case (ADDR)
				ADDR_T1_PSC: rdata_d = {1'b0, timer1_prescaler[0]}; // R10
				ADDR_T1_CNT: rdata_d = cnt_q[0]; // R9
				ADDR_T1_CTL: rdata_d = ctl_q[0];
				ADDR_T2_PSC: rdata_d = {1'b0, timer1_prescaler[1]}; // R10
				ADDR_T2_CNT: rdata_d = cnt_q[1]; // R9
				ADDR_T2_CTL: rdata_d = ctl_q[1]; // R11
				ADDR_IRQ_STAT: rdata_d = {6'h00, ist_q};
				ADDR_IRQ_MASK: rdata_d = {6'h00, imsk_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// every output is a register bit with no logic behind it
	assign RDATA = rdata_q;
	assign TPIN_O = pin_o_q;
	assign TPIN_OE = ctl_q[0][BIT_PIN_DIR]; // R4
	assign T1_REQ = req_q[0];
	assign T2_REQ = req_q[1];
	assign IRQ = irq_q;
endmodule

// ===== dpdt_pkg.sv
// constants shared by the dual prescaled down timer
package dpdt_pkg;
	// register offsets on the data-space port
	localparam logic [7:0] ADDR_T1_PSC = 8'hD2;
	localparam logic [7:0] ADDR_T1_CNT = 8'hD3;
	localparam logic [7:0] ADDR_T1_CTL = 8'hD4;
	localparam logic [7:0] ADDR_T2_PSC = 8'hD5;
	localparam logic [7:0] ADDR_T2_CNT = 8'hD6;
	localparam logic [7:0] ADDR_T2_CTL = 8'hD7;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'hD8;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hD9;

	// status/control field positions
	localparam int BIT_ZERO = 7;
	localparam int BIT_IRQ_EN = 6;
	localparam int BIT_PIN_DIR = 5;
	localparam int BIT_PIN_DATA = 4;
	localparam int BIT_RUN = 3;
	localparam int TAP_MSB = 2;

	// reset values
	localparam logic [7:0] CNT_RST = 8'hFF;
	localparam logic [6:0] PSC_RST = 7'h7F;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// internal clock divided by twelve feeds the prescalers
	localparam int DIV_RATIO = 12;
	localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);
endpackage

// ===== dpdt_sync.sv
// two-flop synchroniser for an outside level
`timescale 1ns/1ps
module dpdt_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	logic meta_q;

	// first flop feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ===== dpdt_presc.sv
// seven-bit down prescaler with selectable tap
`timescale 1ns/1ps
module dpdt_presc (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic tick,
	input wire logic ld,
	input wire logic [6:0] ld_val,
	input wire logic [2:0] tap,
	output logic [6:0] timer1_prescaler,
	output logic fire
);
	import dpdt_pkg::*;

	logic [6:0] psc_q;
	logic [6:0] psc_d;
	logic [6:0] dec;
	logic [2:0] tap_m1;

	// next prescaler value and counter clock from the chosen tap
	always_comb begin
		dec = psc_q - 7'h01;
		tap_m1 = tap - 3'h1;
		psc_d = psc_q;
		fire = 1'b0;
		if (!run) begin
			psc_d = PSC_RST; // R6
		end else if (ld) begin
			psc_d = ld_val;
		end else if (tick) begin
			psc_d = dec; // R7
			if (tap == 3'h0) begin
				fire = 1'b1; // R8
			end else begin
				fire = !psc_q[tap_m1] && dec[tap_m1]; // R8
			end
		end
	end

	// prescaler state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			psc_q <= PSC_RST; // R14
		end else begin
			psc_q <= psc_d;
		end
	end

	assign timer1_prescaler = psc_q;
endmodule

// ===== dpdt_properties.sv
// port checker for the dual prescaled down timer
`timescale 1ns/1ps
module dpdt_props
	import dpdt_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic TPIN_I,
	input wire logic TPIN_O,
	input wire logic TPIN_OE,
	input wire logic T1_REQ,
	input wire logic T2_REQ,
	input wire logic IRQ
);
	logic mapped;

	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);

	// control register writes of each timer
	sequence s_ctl1_wr;
		WR && ADDR == ADDR_T1_CTL;
	endsequence
	sequence s_ctl2_wr;
		WR && ADDR == ADDR_T2_CTL;
	endsequence

	// decoded register window
	assign mapped = ADDR inside {[ADDR_T1_PSC:ADDR_IRQ_MASK]};

	a_read_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data not idle");
	a_unmapped_read: assert property (RD && !mapped |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_psc_top_bit: assert property (RD && (ADDR == ADDR_T1_PSC ||
		ADDR == ADDR_T2_PSC) |=> !RDATA[7])
		else $error("prescaler top bit set");
	a_pin_dir: assert property (s_ctl1_wr |=>
		TPIN_OE == $past(WDATA[BIT_PIN_DIR]))
		else $error("pin enable wrong");
	a_req1_set: assert property (s_ctl1_wr ##0 WDATA[7:6] == 2'h3 |=> T1_REQ)
		else $error("timer 1 request missing");
	a_req1_off: assert property (s_ctl1_wr ##0 !WDATA[6] |=> !T1_REQ)
		else $error("timer 1 request while disabled");
	a_req2_off: assert property (s_ctl2_wr ##0 !WDATA[6] |=> !T2_REQ)
		else $error("timer 2 request while disabled");
	a_irq_masked: assert property (WR && ADDR == ADDR_IRQ_MASK &&
		WDATA == 8'h00 |=> !IRQ)
		else $error("interrupt with mask clear");
	a_reset_quiet: assert property ($fell(RST) |-> RDATA == 8'h00 &&
		!TPIN_O && !TPIN_OE && !T1_REQ && !T2_REQ && !IRQ)
		else $error("outputs not quiet after reset");
endmodule

bind dpdt_top dpdt_props i_props (.CLK(CLK), .RST(RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TPIN_I(TPIN_I),
	.TPIN_O(TPIN_O), .TPIN_OE(TPIN_OE), .T1_REQ(T1_REQ), .T2_REQ(T2_REQ),
	.IRQ(IRQ));

// ===== dpdt_pin_src.sv
// outside source on the timer pin and the wire's resolved level
`timescale 1ns/1ps
module dpdt_pin_src (
	input wire logic lvl,
	input wire logic pin_o,
	input wire logic pin_oe,
	output logic pin
);
	// the device wins while it drives, else the source level
	assign pin = pin_oe ? pin_o : lvl;
endmodule

// ===== dpdt_top_test.sv
// self-checking bench for the dual prescaled down timer
`timescale 1ns/1ps
module dpdt_top_test;
	import dpdt_pkg::*;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [7:0] WDATA = 8'h00;
	logic lvl = 1'b0;
	logic [7:0] RDATA;
	logic TPIN_I, TPIN_O, TPIN_OE, T1_REQ, T2_REQ, IRQ;
	logic [7:0] rst_vals [6] = '{8'h7F, 8'hFF, 8'h00, 8'h7F, 8'hFF, 8'h00};
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;

	dpdt_top i_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .TPIN_I(TPIN_I), .TPIN_O(TPIN_O),
		.TPIN_OE(TPIN_OE), .T1_REQ(T1_REQ), .T2_REQ(T2_REQ), .IRQ(IRQ));
	dpdt_pin_src i_src (.lvl(lvl), .pin_o(TPIN_O), .pin_oe(TPIN_OE),
		.pin(TPIN_I));

	// 40 MHz clock
	initial begin
		forever #12.5 CLK = ~CLK;
	end

	////////////////////////////////////////////////////////////////////////
	// verdict and ending
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// cycle ceiling cuts a hang short
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// one-cycle strobes on the register port
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		chk(RDATA, exp);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(ADDR_T1_PSC + 8'(i), rst_vals[i]);
		end
		rd(8'hD0, 8'h00);
		wr(ADDR_T1_PSC, 8'h15);
		rd(ADDR_T1_PSC, 8'h7F);
		wr(ADDR_T1_CNT, 8'h5A);
		rd(ADDR_T1_CNT, 8'h5A);
		// each tap code doubles the ticks of twelve clocks to zero
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_T2_CTL, 8'h20);
			wr(ADDR_T2_CNT, 8'h01);
			wr(ADDR_T2_CTL, 8'h68 | 8'(k));
			n = 0;
			while (T2_REQ !== 1'b1 && n < 2000) begin
				@(negedge CLK);
				n++;
			end
			chk(8'(n > 12 * (2 ** k - 1) && n <= 12 * 2 ** k + 3), 8'h01);
		end
		rd(ADDR_T2_CNT, 8'h00);
		rd(ADDR_IRQ_STAT, 8'h02);
		chk({7'h00, IRQ}, 8'h00);
		wr(ADDR_IRQ_MASK, 8'h02);
		@(negedge CLK);
		chk({7'h00, IRQ}, 8'h01);
		wr(ADDR_IRQ_STAT, 8'h02);
		@(negedge CLK);
		chk({7'h00, IRQ}, 8'h00);
		wr(ADDR_T2_CTL, 8'hA8);
		@(negedge CLK);
		chk({7'h00, T2_REQ}, 8'h00);
		// event mode counts three pin rises
		wr(ADDR_T1_CNT, 8'h03);
		wr(ADDR_T1_CTL, 8'h08);
		for (int i = 0; i < 6; i++) begin
			@(posedge CLK);
			lvl <= ~lvl;
			repeat (3) @(posedge CLK);
		end
		repeat (6) @(posedge CLK);
		rd(ADDR_T1_CNT, 8'h00);
		rd(ADDR_T1_CTL, 8'h88);
		// gated mode counts only while the pin is high
		wr(ADDR_T1_CNT, 8'h05);
		wr(ADDR_T1_CTL, 8'h18);
		repeat (40) @(posedge CLK);
		rd(ADDR_T1_CNT, 8'h05);
		@(posedge CLK);
		lvl <= 1'b1;
		repeat (36) @(posedge CLK);
		lvl <= 1'b0;
		repeat (6) @(posedge CLK);
		rd(ADDR_T1_CNT, 8'h02);
		// a load while running shows; prescaler bit 7 reads zero
		wr(ADDR_T1_PSC, 8'hD5);
		rd(ADDR_T1_PSC, 8'h55);
		// output mode latches the data bit when writing zero sets the flag
		for (int b = 1; b >= 0; b--) begin
			wr(ADDR_T1_CTL, 8'h20 | 8'(b << 4));
			wr(ADDR_T1_CNT, 8'h00);
			@(negedge CLK);
			chk({6'h00, TPIN_OE, TPIN_O}, 8'h02 | 8'(b));
			chk({7'h00, TPIN_I}, 8'(b));
		end
		rd(ADDR_T1_CTL, 8'hA0);
		wr(ADDR_T1_CTL, 8'hC0);
		@(negedge CLK);
		chk({7'h00, T1_REQ}, 8'h01);
		wr(ADDR_IRQ_MASK, 8'h01);
		@(negedge CLK);
		chk({7'h00, IRQ}, 8'h01);
		wr(ADDR_IRQ_MASK, 8'h00);
		@(negedge CLK);
		chk({7'h00, IRQ}, 8'h00);
		// reset in mid-run puts every timer register back
		repeat (2) @(posedge CLK);
		RST <= 1'b1;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(ADDR_T1_PSC + 8'(i), rst_vals[i]);
		end
		chk({6'h00, T1_REQ, TPIN_OE}, 8'h00);
		end_of_test();
	end
endmodule
